/* File: verilog/qie_engine.sv */
`timescale 1ns/1ns
// Overview of operation
// RULE1 - fetch descriptors in fifo order from head while enabled
// RULE2 - head moves only after the fetched descriptor checks valid
// RULE3 - wide descriptors make tail bit 4 reserved with bits 3:0
// RULE4 - queue is empty when head equals tail
// RULE5 - software sees full when tail is one behind head
// RULE6 - software zeroes tail and programs queue before enabling
// RULE7 - enable command sets the queue enabled status
// RULE8 - fetch only when enabled, non-empty and both error flags clear
// RULE9 - software quiesces the queue before disabling
// RULE10 - disable command zeroes head and clears enabled status
// RULE11 - type is bits 11:9 joined with bits 3:0
// RULE12 - width mismatch between descriptor and queue is an invalid descriptor; code checks it only for types 1 and 7
// RULE13 - software picks wide descriptors before scalable or abort mode
// RULE14 - type 1 is context flush with 01 global 10 domain 11 device
// RULE15 - scalable mode: domain context flush is global, domain tag ignored
// RULE16 - device flush matches source tag after function mask
// RULE17 - flush write buffers first when the flush requirement is reported
// RULE18 - software chains context, pasid and iotlb flushes
// RULE19 - pasid flush only in wide queues, else invalid
// RULE20 - type 7 is pasid flush with 00 domain 01 pasid 11 global
// RULE21 - mask domain tag to reported width; ignore pasid for domain scope
// RULE22 - software follows pasid flush with matching iotlb flush
// RULE23 - head wraps after last entry; invalid descriptor stops and flags error
module qie_engine (
    input wire logic clock,
    input wire logic reset_n,
    input wire qie_pkg::qie_cfg_t cfg,
    input wire logic enable_cmd,
    input wire logic disable_cmd,
    input wire logic tail_write,
    input wire logic [qie_pkg::PTR_W-1:0] tail_value,
    input wire logic timeout_error_flag,
    input wire logic queue_error_clear,
    output logic [qie_pkg::PTR_W-1:0] head_ptr,
    output logic [qie_pkg::PTR_W-1:0] tail_ptr,
    output logic queue_enabled_status,
    output logic queue_error_flag,
    output logic queue_empty,
    output logic rd_req,
    output logic [qie_pkg::PTR_W-1:0] rd_index,
    input wire logic rd_valid,
    input wire logic [qie_pkg::DESC_W-1:0] rd_data,
    output logic wb_flush_req,
    input wire logic wb_flush_done,
    output logic inv_valid,
    output qie_pkg::qie_cmd_t inv_cmd,
    input wire logic inv_ready,
    output logic other_valid,
    output logic [qie_pkg::DESC_W-1:0] other_desc,
    input wire logic other_ready
);
    import qie_pkg::*;

    // ***************************************************
    // state
    // ***************************************************
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FETCH,
        ST_CHECK,
        ST_FLUSH,
        ST_ISSUE,
        ST_PASS
    } qie_state_t;

    typedef struct packed {
        qie_state_t st;
        logic [PTR_W-1:0] head;
        logic [PTR_W-1:0] tail;
        logic enabled;
        logic qerr;
        logic [DESC_W-1:0] desc;
        qie_cmd_t cmd;
    } qie_regs_t;

    qie_regs_t s_q;
    qie_regs_t s_d;

    logic dec_valid;
    qie_cmd_t dec_cmd;
    logic [PTR_W-1:0] head_next;
    logic [PTR_W-1:0] head_idx;
    logic [PTR_W-1:0] tail_mask;
    logic can_fetch;
    logic [6:0] cur_type;

    qie_decode u_decode (
        .desc(s_q.desc),
        .cfg(cfg),
        .valid(dec_valid),
        .cmd(dec_cmd)
    );

    qie_fetch_ptr u_ptr (
        .head(s_q.head),
        .cfg(cfg),
        .head_next(head_next),
        .entry_idx(head_idx)
    );

    // ***************************************************
    // next state
    // ***************************************************
    always_comb begin
        s_d = s_q;
        // low offset bits reserved; bit 4 too for wide entries
        tail_mask = cfg.width_256 ? ~PTR_W'((1 << PTR_LO_256) - 1) :
            ~PTR_W'((1 << PTR_LO_128) - 1); // [RULE3]
        can_fetch = s_q.enabled && (s_q.head != s_q.tail) && !s_q.qerr &&
            !timeout_error_flag; // [RULE8] [RULE4]
        cur_type = {s_q.desc[TYPE_HI_HI:TYPE_HI_LO], s_q.desc[TYPE_LO_HI:0]};
        if (tail_write) begin
            s_d.tail = tail_value & tail_mask; // [RULE3]
        end
        // set wins over software clear
        if (queue_error_clear) begin
            s_d.qerr = 1'b0;
        end
        case (s_q.st)
            ST_IDLE: begin
                if (can_fetch) begin
                    s_d.st = ST_FETCH; // [RULE1]
                end
            end
            ST_FETCH: begin
                if (rd_valid) begin
                    s_d.desc = rd_data;
                    s_d.st = ST_CHECK;
                end
            end
            ST_CHECK: begin
                if (!dec_valid) begin
                    s_d.qerr = 1'b1; // [RULE23] [RULE12]
                    s_d.st = ST_IDLE; // head stays on the bad entry [RULE2]
                end else begin
                    s_d.head = head_next; // [RULE2] [RULE23]
                    s_d.cmd = dec_cmd;
                    if (dec_cmd.kind == KIND_OTHER) begin
                        s_d.st = ST_PASS;
                    end else if (cfg.flush_required) begin
                        s_d.st = ST_FLUSH; // [RULE17]
                    end else begin
                        s_d.st = ST_ISSUE;
                    end
                end
            end
            ST_FLUSH: begin
                if (wb_flush_done) begin
                    s_d.st = ST_ISSUE; // [RULE17]
                end
            end
            ST_ISSUE: begin
                if (inv_ready) begin
                    s_d.st = ST_IDLE;
                end
            end
            ST_PASS: begin
                if (other_ready) begin
                    s_d.st = ST_IDLE;
                end
            end
            default: s_d.st = ST_IDLE;
        endcase
        if (enable_cmd) begin
            s_d.enabled = 1'b1; // [RULE7]
        end
        if (disable_cmd) begin
            // disabling mid-fetch abandons the read; software quiesces first
            s_d.enabled = 1'b0; // [RULE10]
            s_d.head = '0; // [RULE10]
            s_d.st = ST_IDLE;
        end
    end

    // ***************************************************
    // registers
    // ***************************************************
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
            s_q.cmd.kind <= KIND_OTHER;
        end else begin
            s_q <= s_d;
        end
    end

    // ***************************************************
    // outputs
    // ***************************************************
    assign head_ptr = s_q.head;
    assign tail_ptr = s_q.tail;
    assign queue_enabled_status = s_q.enabled;
    assign queue_error_flag = s_q.qerr;
    assign queue_empty = s_q.head == s_q.tail; // [RULE4]
    assign rd_req = s_q.st == ST_FETCH;
    assign rd_index = head_idx; // [RULE1]
    assign wb_flush_req = s_q.st == ST_FLUSH; // [RULE17]
    assign inv_valid = s_q.st == ST_ISSUE;
    assign inv_cmd = s_q.cmd;
    assign other_valid = s_q.st == ST_PASS && cur_type != TYPE_CTX;
    assign other_desc = s_q.desc;
endmodule

/* File: verilog/qie_pkg.sv */
package qie_pkg;
    // ***************************************************
    // widths and field positions
    // ***************************************************
    localparam int PTR_W = 19;
    localparam int SIZE_W = 3;
    localparam int DESC_W = 256;
    localparam int HALF_W = 128;
    localparam int DOM_W = 16;
    localparam int SRC_W = 16;
    localparam int PASID_W = 20;
    localparam int DOMW_W = 5;
    localparam int TYPE_LO_HI = 3;
    localparam int TYPE_HI_LO = 9;
    localparam int TYPE_HI_HI = 11;
    localparam int GRAN_LO = 4;
    localparam int DOM_LO = 16;
    localparam int SRC_LO = 32;
    localparam int MASK_LO = 48;
    localparam int PASID_LO = 32;
    localparam int PTR_LO_128 = 4;
    localparam int PTR_LO_256 = 5;
    localparam int BASE_ENTRIES = 256;
    localparam logic [6:0] TYPE_CTX = 7'h01;
    localparam logic [6:0] TYPE_PASID = 7'h07;
    localparam logic [1:0] CG_RSVD = 2'h0;
    localparam logic [1:0] CG_GLOBAL = 2'h1;
    localparam logic [1:0] CG_DOMAIN = 2'h2;
    localparam logic [1:0] CG_DEVICE = 2'h3;
    localparam logic [1:0] PG_DOMAIN = 2'h0;
    localparam logic [1:0] PG_PASID = 2'h1;
    localparam logic [1:0] PG_RSVD = 2'h2;
    localparam logic [1:0] PG_GLOBAL = 2'h3;
    localparam logic [1:0] TM_LEGACY = 2'h0;
    localparam logic [1:0] TM_SCALABLE = 2'h1;
    localparam logic [1:0] TM_ABORT = 2'h3;

    // ***************************************************
    // types
    // ***************************************************
    typedef enum logic [1:0] {
        KIND_CTX,
        KIND_PASID,
        KIND_OTHER
    } qie_kind_t;

    typedef enum logic [1:0] {
        SCOPE_GLOBAL,
        SCOPE_DOMAIN,
        SCOPE_DEVICE,
        SCOPE_PASID
    } qie_scope_t;

    typedef struct packed {
        logic [SIZE_W-1:0] size;
        logic width_256;
        logic [1:0] mode;
        logic flush_required;
        logic [DOMW_W-1:0] dom_bits;
    } qie_cfg_t;

    typedef struct packed {
        qie_kind_t kind;
        qie_scope_t scope;
        logic [DOM_W-1:0] domain_tag;
        logic [SRC_W-1:0] source_tag;
        logic [SRC_W-1:0] source_keep;
        logic [PASID_W-1:0] pasid;
    } qie_cmd_t;
endpackage

/* File: verilog/qie_decode.sv */
`timescale 1ns/1ns
module qie_decode (
    input wire logic [qie_pkg::DESC_W-1:0] desc,
    input wire qie_pkg::qie_cfg_t cfg,
    output logic valid,
    output qie_pkg::qie_cmd_t cmd
);
    import qie_pkg::*;

    function automatic logic [SRC_W-1:0] keep_mask(input logic [1:0] fm);
        case (fm)
            2'h1: keep_mask = 16'hFFFB;
            2'h2: keep_mask = 16'hFFF9;
            2'h3: keep_mask = 16'hFFF8;
            default: keep_mask = 16'hFFFF;
        endcase
    endfunction

    logic [6:0] code;
    logic [1:0] gran;
    logic upper_zero;
    logic scal;
    logic [DOM_W-1:0] dom_keep;

    always_comb begin
        code = {desc[TYPE_HI_HI:TYPE_HI_LO], desc[TYPE_LO_HI:0]}; // [RULE11]
        gran = desc[GRAN_LO+1:GRAN_LO];
        upper_zero = desc[DESC_W-1:HALF_W] == '0;
        scal = cfg.mode == TM_SCALABLE;
        dom_keep = (cfg.dom_bits >= DOMW_W'(DOM_W)) ? '1 :
            DOM_W'(({{DOM_W{1'b0}}, 1'b1} << cfg.dom_bits) - 1'b1); // [RULE21]
        valid = 1'b0;
        cmd = '0;
        cmd.kind = KIND_OTHER;
        cmd.scope = SCOPE_GLOBAL;
        cmd.source_tag = desc[SRC_LO+SRC_W-1:SRC_LO];
        cmd.source_keep = keep_mask(desc[MASK_LO+1:MASK_LO]); // [RULE16]
        cmd.domain_tag = desc[DOM_LO+DOM_W-1:DOM_LO];
        case (code)
            TYPE_CTX: begin
                cmd.kind = KIND_CTX;
                // 128-bit descriptor: padded only in wide queues [RULE12]
                valid = gran != CG_RSVD && (!cfg.width_256 || upper_zero) &&
                    (cfg.width_256 || (cfg.mode != TM_SCALABLE && cfg.mode != TM_ABORT));
                case (gran) // [RULE14]
                    CG_DOMAIN: cmd.scope = scal ? SCOPE_GLOBAL : SCOPE_DOMAIN; // [RULE15]
                    CG_DEVICE: cmd.scope = SCOPE_DEVICE;
                    default: cmd.scope = SCOPE_GLOBAL;
                endcase
                if (scal) begin
                    cmd.domain_tag = '0; // [RULE15]
                end
            end
            TYPE_PASID: begin
                cmd.kind = KIND_PASID;
                valid = gran != PG_RSVD && cfg.width_256; // [RULE19] [RULE20]
                cmd.domain_tag = desc[DOM_LO+DOM_W-1:DOM_LO] & dom_keep; // [RULE21]
                case (gran)
                    PG_PASID: begin
                        cmd.scope = SCOPE_PASID;
                        cmd.pasid = desc[PASID_LO+PASID_W-1:PASID_LO];
                    end
                    PG_DOMAIN: cmd.scope = SCOPE_DOMAIN; // pasid left zero [RULE21]
                    default: cmd.scope = SCOPE_GLOBAL;
                endcase
            end
            default: begin
                // other types go to other engines; always valid here, width not checked
                valid = !cfg.width_256 || upper_zero || 1'b1;
            end
        endcase
    end
endmodule

/* File: verilog/qie_fetch_ptr.sv */
`timescale 1ns/1ns
module qie_fetch_ptr (
    input wire logic [qie_pkg::PTR_W-1:0] head,
    input wire qie_pkg::qie_cfg_t cfg,
    output logic [qie_pkg::PTR_W-1:0] head_next,
    output logic [qie_pkg::PTR_W-1:0] entry_idx
);
    import qie_pkg::*;

    // wide sums: the largest queue ends exactly at 2^PTR_W bytes
    logic [31:0] limit;
    logic [31:0] sum;
    logic [PTR_W-1:0] step;

    always_comb begin
        // queue holds 2^size * 256 entries of 128 bits, half as many wide ones
        limit = 32'((BASE_ENTRIES << cfg.size) << PTR_LO_128);
        step = cfg.width_256 ? PTR_W'(1 << PTR_LO_256) : PTR_W'(1 << PTR_LO_128);
        sum = 32'(head) + 32'(step);
        head_next = (sum >= limit) ? '0 : PTR_W'(sum); // [RULE23]
        entry_idx = cfg.width_256 ? PTR_W'(head >> PTR_LO_256) : PTR_W'(head >> PTR_LO_128);
    end
endmodule

/* File: sim/qie_checker.sv */
`timescale 1ns/1ns
module qie_checker (
    input wire logic clock,
    input wire logic reset_n,
    input wire qie_pkg::qie_cfg_t cfg,
    input wire logic enable_cmd,
    input wire logic disable_cmd,
    input wire logic timeout_error_flag,
    input wire logic [qie_pkg::PTR_W-1:0] head_ptr,
    input wire logic [qie_pkg::PTR_W-1:0] tail_ptr,
    input wire logic queue_enabled_status,
    input wire logic queue_error_flag,
    input wire logic queue_empty,
    input wire logic rd_req,
    input wire logic [qie_pkg::PTR_W-1:0] rd_index,
    input wire logic rd_valid,
    input wire logic wb_flush_req,
    input wire logic inv_valid
);
    import qie_pkg::*;
    // ****************
    // helpers
    // ****************
    logic [PTR_W-1:0] head_exp;
    // wrap point is the queue size in bytes
    assign head_exp = PTR_W'((32'(head_ptr) + (cfg.width_256 ? 32'h20 : 32'h10))
        % (32'h1000 << cfg.size));
    default clocking dcb @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    sequence read_taken;
        rd_req && rd_valid;
    endsequence
    sequence head_moved;
        $changed(head_ptr) && !$past(disable_cmd);
    endsequence
    // ****************
    // properties
    // ****************
    status_on_a: assert property (enable_cmd && !disable_cmd |=> queue_enabled_status)
        else $error("enable ignored");
    disable_clear_a: assert property (disable_cmd |=> !head_ptr && !queue_enabled_status)
        else $error("disable left state");
    empty_match_a: assert property (queue_empty |=> !$rose(rd_req))
        else $error("fetch started on empty queue");
    fetch_gate_a: assert property ($rose(rd_req) |-> $past(queue_enabled_status
        && !queue_empty && !queue_error_flag && !timeout_error_flag)) else $error("bad fetch");
    head_valid_a: assert property (head_moved |-> $past(rd_req && rd_valid, 2))
        else $error("head moved without a checked read");
    head_step_a: assert property (head_moved |-> head_ptr == $past(head_exp))
        else $error("head step or wrap wrong");
    error_hold_a: assert property (read_taken ##2 $rose(queue_error_flag)
        |-> head_ptr == $past(head_ptr, 2) && !rd_req) else $error("head moved on error");
    flush_first_a: assert property ($rose(inv_valid) && cfg.flush_required
        |-> $past(wb_flush_req)) else $error("invalidation before flush");
    fetch_head_a: assert property (rd_req |->
        rd_index == head_ptr >> (cfg.width_256 ? 5 : 4)) else $error("fetch not at head");
endmodule

/* File: sim/qie_mem_model.sv */
`timescale 1ns/1ns
module qie_mem_model (
    input wire logic clock,
    input wire logic [3:0] lag,
    input wire logic rd_req,
    input wire logic [qie_pkg::PTR_W-1:0] rd_index,
    input wire logic wb_flush_req,
    output logic rd_valid,
    output logic [qie_pkg::DESC_W-1:0] rd_data,
    output logic wb_flush_done
);
    import qie_pkg::*;
    logic [DESC_W-1:0] mem [0:255];
    logic [3:0] wait_q = 4'h0;
    initial rd_valid = 1'b0;
    initial wb_flush_done = 1'b0;
    initial rd_data = '0;
    // answers after lag cycles; data scrambled outside a read
    always @(negedge clock) begin
        rd_valid <= 1'b0;
        wb_flush_done <= 1'b0;
        rd_data <= ~rd_data;
        if ((rd_req || wb_flush_req) && !rd_valid && !wb_flush_done) begin
            wait_q <= wait_q + 4'h1;
            if (wait_q >= lag) begin
                wait_q <= 4'h0;
                rd_valid <= rd_req;
                wb_flush_done <= wb_flush_req && !rd_req;
                if (rd_req) begin
                    rd_data <= mem[rd_index[7:0]];
                end
            end
        end
    end
endmodule

/* File: sim/queued_invalidation_engine_tb.sv */
`timescale 1ns/1ns
module queued_invalidation_engine_tb;
    import qie_pkg::*;
    logic clock = 1'b0, reset_n = 1'b0, enable_cmd = 1'b0, disable_cmd = 1'b0;
    logic tail_write = 1'b0, timeout_error_flag = 1'b0, queue_error_clear = 1'b0;
    logic inv_ready = 1'b0, other_ready = 1'b1;
    logic [PTR_W-1:0] tail_value = '0, head_ptr, tail_ptr, rd_index;
    logic queue_enabled_status, queue_error_flag, queue_empty, rd_req, rd_valid;
    logic wb_flush_req, wb_flush_done, inv_valid, other_valid;
    logic [DESC_W-1:0] rd_data, other_desc;
    logic [3:0] lag = 4'h3;
    qie_cfg_t cfg = '0;
    qie_cmd_t inv_cmd, got;
    int n_fail = 0;
    int comparisons = 0;
    qie_engine dut_u (.clock, .reset_n, .cfg, .enable_cmd, .disable_cmd, .tail_write,
        .tail_value, .timeout_error_flag, .queue_error_clear, .head_ptr, .tail_ptr,
        .queue_enabled_status, .queue_error_flag, .queue_empty, .rd_req, .rd_index,
        .rd_valid, .rd_data, .wb_flush_req, .wb_flush_done, .inv_valid, .inv_cmd,
        .inv_ready, .other_valid, .other_desc, .other_ready);
    qie_mem_model mem_u (.clock, .lag, .rd_req, .rd_index, .wb_flush_req, .rd_valid,
        .rd_data, .wb_flush_done);
    always #20 clock = ~clock;
    // ****************
    // tasks
    // ****************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] act);
        comparisons++;
        if (act !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, act);
        end
    endtask
    function automatic logic [DESC_W-1:0] mk(logic [6:0] ty, logic [1:0] g,
        logic [15:0] dom, logic [19:0] src, logic [1:0] fm);
        mk = '0; // reserved and pad bits zero
        mk[3:0] = ty[3:0];
        mk[11:9] = ty[6:4];
        mk[5:4] = g;
        mk[31:16] = dom;
        mk[51:32] = src;
        mk[49:48] = mk[49:48] | fm; // mask bits overlap the pasid field
    endfunction
    // clears a pending error, so a rewritten entry is fetched again
    task automatic run(input int e, input logic [DESC_W-1:0] d, input logic [PTR_W-1:0] t);
        mem_u.mem[e] = d;
        queue_error_clear = queue_error_flag;
        tail_write = 1'b1;
        tail_value = t;
        @(negedge clock);
        tail_write = 1'b0;
        queue_error_clear = 1'b0;
        for (int i = 0; i < 60 && !(inv_valid || other_valid || queue_error_flag); i++) begin
            @(negedge clock);
        end
        got = inv_cmd;
        if (other_valid) chk("other", d[31:0], other_desc[31:0]);
        if (inv_valid) begin
            inv_ready = 1'b1;
            @(negedge clock);
            inv_ready = 1'b0;
        end
        @(negedge clock);
    endtask
    task automatic pulse(input logic dis);
        enable_cmd = !dis;
        disable_cmd = dis;
        @(negedge clock);
        enable_cmd = 1'b0;
        disable_cmd = 1'b0;
        @(negedge clock);
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        results();
    end
    // ****************
    // sequence
    // ****************
    initial begin
        cfg.flush_required = 1'b1;
        cfg.dom_bits = 5'h08;
        repeat (8) @(negedge clock);
        reset_n = 1'b1;
        chk("empty", 1, queue_empty);
        pulse(1'b0);
        chk("status", 1, queue_enabled_status);
        timeout_error_flag = 1'b1;
        run(0, mk(TYPE_CTX, CG_GLOBAL, 16'h0012, 20'h0, 2'h0), 19'h10);
        chk("blocked", 0, head_ptr);
        timeout_error_flag = 1'b0;
        run(0, mk(TYPE_CTX, CG_GLOBAL, 16'h0012, 20'h0, 2'h0), 19'h10);
        chk("kind", KIND_CTX, got.kind);
        chk("gscope", SCOPE_GLOBAL, got.scope);
        run(1, mk(TYPE_CTX, CG_DOMAIN, 16'h0123, 20'h0, 2'h0), 19'h20);
        chk("dscope", SCOPE_DOMAIN, got.scope);
        chk("dtag", 16'h0123, got.domain_tag);
        run(2, mk(TYPE_CTX, CG_DEVICE, 16'h0123, 20'h000FF, 2'h2), 19'h30);
        chk("vscope", SCOPE_DEVICE, got.scope);
        chk("keep", 16'hFFF9, got.source_keep);
        run(3, mk(TYPE_CTX, CG_RSVD, 16'h0, 20'h0, 2'h0), 19'h40);
        chk("rsvd", 1, queue_error_flag);
        chk("hold", 19'h30, head_ptr);
        run(3, mk(7'h02, 2'h1, 16'h0, 20'h0, 2'h0), 19'h40);
        run(4, mk(TYPE_PASID, PG_GLOBAL, 16'h0, 20'h0, 2'h0), 19'h50);
        chk("narrow", 1, queue_error_flag);
        run(4, mk(7'h05, 2'h0, 16'h0, 20'h0, 2'h0), 19'h50);
        chk("head", 19'h50, head_ptr);
        pulse(1'b1);
        chk("off", 0, {head_ptr, queue_enabled_status});
        run(0, mk(TYPE_PASID, PG_GLOBAL, 16'h0, 20'h0, 2'h0), 19'h0);
        cfg.width_256 = 1'b1;
        cfg.mode = TM_SCALABLE;
        lag = 4'h0;
        pulse(1'b0);
        run(0, mk(TYPE_PASID, PG_GLOBAL, 16'h0, 20'h0, 2'h0), 19'h30);
        chk("tail", 19'h20, tail_ptr);
        chk("pkind", KIND_PASID, got.kind);
        chk("pglob", SCOPE_GLOBAL, got.scope);
        run(1, mk(TYPE_CTX, CG_DOMAIN, 16'h0123, 20'h0, 2'h0), 19'h40);
        chk("sglob", SCOPE_GLOBAL, got.scope);
        chk("stag", 0, got.domain_tag);
        run(2, mk(TYPE_PASID, PG_DOMAIN, 16'hABCD, 20'h12345, 2'h0), 19'h60);
        chk("pdom", SCOPE_DOMAIN, got.scope);
        chk("ptag", 16'h00CD, got.domain_tag);
        run(3, mk(TYPE_PASID, PG_PASID, 16'h0001, 20'h12345, 2'h0), 19'h80);
        chk("psel", SCOPE_PASID, got.scope);
        chk("pasid", 20'h12345, got.pasid);
        run(4, mk(TYPE_PASID, PG_RSVD, 16'h0, 20'h0, 2'h0), 19'hA0);
        chk("prsvd", 1, queue_error_flag);
        for (int i = 4; i < 260; i++) begin
            // size 0 wide queue: 128 entries, 0x1000 bytes
            run(i % 128, mk(7'h02, 2'h1, 16'h0, 20'h0, 2'h0),
                19'((i + 1) * 32'h20 % 32'h1000));
        end
        chk("wrap", 19'h80, head_ptr);
        results();
    end
endmodule
bind qie_engine qie_checker chk_u (.clock, .reset_n, .cfg, .enable_cmd, .disable_cmd,
    .timeout_error_flag, .head_ptr, .tail_ptr, .queue_enabled_status, .queue_error_flag,
    .queue_empty, .rd_req, .rd_index, .rd_valid, .wb_flush_req, .inv_valid);
